//--- hdl/vicm_defines.svh
// Functional notes
// - Compare writes mask bit 1 when comparison holds, else 0.
// - Compare result is one mask bit per element in a single register.
// - Destination may be mask register zero; its bit is read before being written.
// - eq/ne/le in vector, scalar, immediate; lt vector/scalar; gt scalar/immediate.
// - Compare immediate is 5 bits, always sign-extended, unsigned compares included.
// - No ge-scalar, lt-immediate or ge-immediate encodings; they are refused.
// - Masked compare under undisturbed policy keeps old bits of inactive elements.
// - Compare destinations are always handled tail-agnostic.
// - Signed and unsigned min and max, second operand vector or scalar.
// - Multiply forms the 2*width product; low form returns its low half.
// - High forms return upper half: signed, unsigned, signed-by-unsigned.
// - No unsigned-vector by signed-scalar high multiply exists.
// - High multiply has no scaling, rounding, saturation or overflow flag.
// - Divide and remainder match scalar results, incl. divide by zero and overflow.
// - Narrowing logical right shift of 2*width source, zero fill, low half written.
// - Narrowing arithmetic right shift of 2*width source, sign fill, low half.
// - Narrowing logical shift by zero truncates to the low half.
// - Narrowing shifts use only the low lg2(2*width) amount bits.
// - Narrowing shift immediate is 5 bits, zero-extended.
`ifndef VICM_DEFINES_SVH
`define VICM_DEFINES_SVH
`define VICM_ELEM_W 32
`define VICM_IDX_W 8
`define VICM_IMM_W 5
`define VICM_RST_READY 1'b1
`define VICM_RST_FLAG 1'b0
`endif

//--- hdl/vicm_pkg.sv
package vicm_pkg;
  typedef enum logic [4:0] {
    OP_SEQ    = 5'h00,
    OP_SNE    = 5'h01,
    OP_SLTU   = 5'h02,
    OP_SLT    = 5'h03,
    OP_SLEU   = 5'h04,
    OP_SLE    = 5'h05,
    OP_SGTU   = 5'h06,
    OP_SGT    = 5'h07,
    OP_MINU   = 5'h08,
    OP_MIN    = 5'h09,
    OP_MAXU   = 5'h0a,
    OP_MAX    = 5'h0b,
    OP_MUL    = 5'h0c,
    OP_MULH   = 5'h0d,
    OP_MULHU  = 5'h0e,
    OP_MULHSU = 5'h0f,
    OP_DIVU   = 5'h10,
    OP_DIV    = 5'h11,
    OP_REMU   = 5'h12,
    OP_REM    = 5'h13,
    OP_NSRL   = 5'h14,
    OP_NSRA   = 5'h15
  } vicm_op_t;
  typedef enum logic [1:0] {
    SRC_VEC = 2'b00,
    SRC_SCA = 2'b01,
    SRC_IMM = 2'b10
  } vicm_src_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DIV  = 2'b01
  } vicm_st_t;
endpackage

//--- hdl/vicm_div.sv
`include "vicm_defines.svh"
module vicm_div
  import vicm_pkg::*;
#(
  parameter int W = `VICM_ELEM_W
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Start
  input  wire logic         start,
  input  wire logic         sgn,
  input  wire logic [W-1:0] dividend,
  input  wire logic [W-1:0] divisor,
  // Result
  output logic              done_r,
  output logic [W-1:0]      quot_r,
  output logic [W-1:0]      rem_r
);
  localparam int CW = $clog2(W + 1);
  logic [CW-1:0] cnt_r;
  logic [W-1:0]  q_r;
  logic [W-1:0]  r_r;
  logic [W-1:0]  d_r;
  logic          neg_q_r;
  logic          neg_r_r;
  wire  [W-1:0]  min_val = {1'b1, {(W-1){1'b0}}};
  wire           div_zero = (divisor == '0);
  wire           div_ovf = sgn && (dividend == min_val) && (divisor == '1);
  wire  [W-1:0]  mag_a = (sgn && dividend[W-1]) ? W'(-dividend) : dividend;
  wire  [W-1:0]  mag_b = (sgn && divisor[W-1]) ? W'(-divisor) : divisor;
  // One restoring step
  wire  [W:0]    rt = {r_r, q_r[W-1]};
  wire  [W:0]    diff = rt - {1'b0, d_r};
  wire           ge = !diff[W];
  wire  [W-1:0]  r_nxt = ge ? diff[W-1:0] : rt[W-1:0];
  wire  [W-1:0]  q_nxt = {q_r[W-2:0], ge};
  wire           last = (cnt_r == CW'(1));

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r   <= '0;
      q_r     <= '0;
      r_r     <= '0;
      d_r     <= '0;
      neg_q_r <= 1'b0;
      neg_r_r <= 1'b0;
      done_r  <= 1'b0;
      quot_r  <= '0;
      rem_r   <= '0;
    end
    else
    begin
      done_r <= 1'b0;
      if (start && div_zero)
      begin
        done_r <= 1'b1;
        quot_r <= '1;
        rem_r  <= dividend;
      end
      else if (start && div_ovf)
      begin
        done_r <= 1'b1;
        quot_r <= dividend;
        rem_r  <= '0;
      end
      else if (start)
      begin
        cnt_r   <= CW'(W);
        q_r     <= mag_a;
        r_r     <= '0;
        d_r     <= mag_b;
        neg_q_r <= sgn && (dividend[W-1] ^ divisor[W-1]);
        neg_r_r <= sgn && dividend[W-1];
      end
      else if (cnt_r != '0)
      begin
        cnt_r <= cnt_r - CW'(1);
        q_r   <= q_nxt;
        r_r   <= r_nxt;
        if (last)
        begin
          done_r <= 1'b1;
          quot_r <= neg_q_r ? W'(-q_nxt) : q_nxt;
          rem_r  <= neg_r_r ? W'(-r_nxt) : r_nxt;
        end
      end
    end
  end
endmodule

//--- hdl/vicm_unit.sv
`include "vicm_defines.svh"
module vicm_unit
  import vicm_pkg::*;
#(
  parameter int ELEM_W = `VICM_ELEM_W,
  parameter int IDX_W  = `VICM_IDX_W
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Request
  input  wire logic                req_valid,
  input  vicm_op_t                 req_op,
  input  vicm_src_t                req_src,
  input  wire logic [2*ELEM_W-1:0] req_wide,
  input  wire logic [ELEM_W-1:0]   req_vec,
  input  wire logic [ELEM_W-1:0]   req_scalar,
  input  wire logic [4:0]          req_imm,
  input  wire logic [IDX_W-1:0]    req_idx,
  // Mask and policy
  input  wire logic                mask_enable_field,
  input  wire logic                mask_v0_bit,
  input  wire logic                mask_undisturbed,
  input  wire logic [ELEM_W-1:0]   req_old_elem,
  input  wire logic                req_old_mask_bit,
  // Answer
  output logic                     req_ready_r,
  output logic                     res_valid_r,
  output logic [ELEM_W-1:0]        res_data_r,
  output logic                     res_mask_bit_r,
  output logic                     res_is_mask_r,
  output logic                     res_tail_agnostic_r,
  output logic                     res_write_r,
  output logic                     res_illegal_r,
  output logic [IDX_W-1:0]         res_idx_r
);
  localparam int W = ELEM_W;
  localparam int SH_W = $clog2(2 * W);
  localparam int DIV_MAX_LAT = W + 2;

  function automatic logic illegal_fn(input vicm_op_t op, input vicm_src_t src);
    logic bad;
    bad = (src != SRC_VEC) && (src != SRC_SCA) && (src != SRC_IMM);
    case (op)
      OP_SEQ, OP_SNE, OP_SLEU, OP_SLE, OP_NSRL, OP_NSRA: illegal_fn = bad;
      OP_SLTU, OP_SLT:  illegal_fn = bad || (src == SRC_IMM);
      OP_SGTU, OP_SGT:  illegal_fn = bad || (src == SRC_VEC);
      OP_MINU, OP_MIN, OP_MAXU, OP_MAX,
      OP_MUL, OP_MULH, OP_MULHU, OP_MULHSU,
      OP_DIVU, OP_DIV, OP_REMU, OP_REM: illegal_fn = bad || (src == SRC_IMM);
      default:          illegal_fn = 1'b1;
    endcase
  endfunction

  function automatic logic cmp_fn(input vicm_op_t op, input logic eq,
                                  input logic ltu, input logic lt);
    case (op)
      OP_SEQ:  cmp_fn = eq;
      OP_SNE:  cmp_fn = !eq;
      OP_SLTU: cmp_fn = ltu;
      OP_SLT:  cmp_fn = lt;
      OP_SLEU: cmp_fn = ltu || eq;
      OP_SLE:  cmp_fn = lt || eq;
      OP_SGTU: cmp_fn = !(ltu || eq);
      OP_SGT:  cmp_fn = !(lt || eq);
      default: cmp_fn = 1'b0;
    endcase
  endfunction

  vicm_st_t st_r;
  logic     h_active_r;
  logic     h_undist_r;
  logic     h_rem_r;
  logic [W-1:0] h_old_r;
  logic [IDX_W-1:0] h_idx_r;
  logic         div_done;
  logic [W-1:0] div_quot;
  logic [W-1:0] div_rem;

  // Operand selection
  wire           take = req_valid && req_ready_r;
  wire [W-1:0]   a = req_wide[W-1:0];
  wire [W-1:0]   imm_sx = W'($signed(req_imm));
  wire [W-1:0]   imm_zx = {{(W-5){1'b0}}, req_imm};
  wire [W-1:0]   b = (req_src == SRC_VEC) ? req_vec :
                     (req_src == SRC_SCA) ? req_scalar : imm_sx;
  wire [SH_W-1:0] shamt = (req_src == SRC_IMM) ? imm_zx[SH_W-1:0]
                                               : b[SH_W-1:0];

  // Classification
  wire illegal = illegal_fn(req_op, req_src);
  wire is_cmp = (req_op <= OP_SGT);
  wire is_div = (req_op >= OP_DIVU) && (req_op <= OP_REM);
  wire div_go = take && is_div && !illegal;
  wire active = mask_enable_field || mask_v0_bit;

  // Compare and min/max
  wire eq  = (a == b);
  wire ltu = (a < b);
  wire lt  = ($signed(a) < $signed(b));
  wire cmp = cmp_fn(req_op, eq, ltu, lt);
  wire [W-1:0] minmax = (req_op == OP_MINU) ? (ltu ? a : b) :
                        (req_op == OP_MIN)  ? (lt ? a : b) :
                        (req_op == OP_MAXU) ? (ltu ? b : a) :
                                              (lt ? b : a);

  // Multiply: operands extended by one bit so one signed product covers all forms
  wire a_sgn = (req_op != OP_MULHU) && a[W-1];
  wire b_sgn = ((req_op == OP_MULH) || (req_op == OP_MUL)) && b[W-1];
  wire signed [W:0]     a_x = {a_sgn, a};
  wire signed [W:0]     b_x = {b_sgn, b};
  wire signed [2*W+1:0] prod = a_x * b_x;
  wire [W-1:0] mul_lo = prod[W-1:0];
  wire [W-1:0] mul_hi = prod[2*W-1:W];

  // Narrowing shifts
  wire [2*W-1:0] srl_w = req_wide >> shamt;
  wire [2*W-1:0] sra_w = $signed(req_wide) >>> shamt;

  wire [W-1:0] alu_res = (req_op == OP_MUL)  ? mul_lo :
                         (req_op == OP_NSRL) ? srl_w[W-1:0] :
                         (req_op == OP_NSRA) ? sra_w[W-1:0] :
                         (req_op <= OP_MAX)  ? minmax : mul_hi;

  // Inactive elements: old value when undisturbed, all ones when agnostic
  wire [W-1:0] data_nxt = active ? alu_res
                        : (mask_undisturbed ? req_old_elem : '1);
  wire mbit_nxt = active ? cmp
                : (mask_undisturbed ? req_old_mask_bit : 1'b1);
  wire [W-1:0] div_pick = h_rem_r ? div_rem : div_quot;
  wire [W-1:0] div_data = h_active_r ? div_pick
                        : (h_undist_r ? h_old_r : '1);

  vicm_div #(
    .W (W)
  ) u_div (
    .sys_clk  (sys_clk),
    .rstn     (rstn),
    .start    (div_go),
    .sgn      ((req_op == OP_DIV) || (req_op == OP_REM)),
    .dividend (a),
    .divisor  (b),
    .done_r   (div_done),
    .quot_r   (div_quot),
    .rem_r    (div_rem)
  );

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r       <= ST_IDLE;
      h_active_r <= 1'b0;
      h_undist_r <= 1'b0;
      h_rem_r    <= 1'b0;
      h_old_r    <= '0;
      h_idx_r    <= '0;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (div_go)
          begin
            st_r       <= ST_DIV;
            h_active_r <= active;
            h_undist_r <= mask_undisturbed;
            h_rem_r    <= req_op >= OP_REMU;
            h_old_r    <= req_old_elem;
            h_idx_r    <= req_idx;
          end
        end
        ST_DIV:
        begin
          if (div_done)
          begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_ready_r         <= `VICM_RST_READY;
      res_valid_r         <= `VICM_RST_FLAG;
      res_data_r          <= '0;
      res_mask_bit_r      <= `VICM_RST_FLAG;
      res_is_mask_r       <= `VICM_RST_FLAG;
      res_tail_agnostic_r <= `VICM_RST_FLAG;
      res_write_r         <= `VICM_RST_FLAG;
      res_illegal_r       <= `VICM_RST_FLAG;
      res_idx_r           <= '0;
    end
    else if (st_r == ST_DIV)
    begin
      res_valid_r <= div_done;
      req_ready_r <= div_done;
      if (div_done)
      begin
        res_data_r          <= div_data;
        res_mask_bit_r      <= 1'b0;
        res_is_mask_r       <= 1'b0;
        res_tail_agnostic_r <= 1'b0;
        res_write_r         <= 1'b1;
        res_illegal_r       <= 1'b0;
        res_idx_r           <= h_idx_r;
      end
    end
    else
    begin
      res_valid_r <= take && !div_go;
      req_ready_r <= !div_go;
      if (take && !div_go)
      begin
        res_data_r          <= (is_cmp || illegal) ? '0 : data_nxt;
        res_mask_bit_r      <= is_cmp && !illegal && mbit_nxt;
        res_is_mask_r       <= is_cmp;
        res_tail_agnostic_r <= is_cmp;
        res_write_r         <= !illegal;
        res_illegal_r       <= illegal;
        res_idx_r           <= req_idx;
      end
    end
  end

  // Checks
  sequence s_div_take;
    take && is_div && !illegal;
  endsequence
  sequence s_div_zero;
    take && (req_op == OP_DIVU) && !illegal && (b == '0) && active;
  endsequence

  AST_CMP_HOLDS: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && is_cmp && !illegal && active |=> res_mask_bit_r == $past(cmp) && res_is_mask_r)
    else $error("compare mask bit does not follow comparison");
  AST_MASK_KEEP: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && is_cmp && !illegal && !active && mask_undisturbed
    |=> res_mask_bit_r == $past(req_old_mask_bit))
    else $error("inactive compare bit not kept");
  AST_TAIL_AGN: assert property (@(posedge sys_clk) disable iff (!rstn)
    res_valid_r && res_is_mask_r |-> res_tail_agnostic_r)
    else $error("compare result not tail agnostic");
  AST_REFUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (req_op == OP_SLT) && (req_src == SRC_IMM)
    |=> res_valid_r && res_illegal_r && !res_write_r)
    else $error("less-than immediate not refused");
  AST_IMM_SEXT: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (req_op == OP_SLEU) && (req_src == SRC_IMM) && active
    && (req_imm == 5'h1f) && (a == '1) |=> res_mask_bit_r)
    else $error("compare immediate not sign-extended");
  AST_MUL_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (req_op == OP_MUL) && (req_src != SRC_IMM) && active
    |=> res_data_r == W'($past(a) * $past(b)))
    else $error("low product half wrong");
  AST_MULHU: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (req_op == OP_MULHU) && (req_src != SRC_IMM) && active
    |=> res_data_r == W'(({{W{1'b0}}, $past(a)} * {{W{1'b0}}, $past(b)}) >> W))
    else $error("unsigned high product half wrong");
  AST_NSRL: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (req_op == OP_NSRL) && (req_src == SRC_IMM) && active
    |=> res_data_r == W'($past(req_wide) >> $past(req_imm)))
    else $error("narrowing logical shift wrong");
  AST_DIV_BUSY: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_div_take |=> !req_ready_r && !res_valid_r)
    else $error("ready not dropped during divide");
  AST_DIV_ZERO: assert property (@(posedge sys_clk) disable iff (!rstn)
    s_div_zero |-> ##[1:DIV_MAX_LAT] (res_valid_r && res_data_r == '1))
    else $error("divide by zero result wrong");
endmodule

//--- bench/vicm_issue_model.sv
module vicm_issue_model
  import vicm_pkg::*;
(
  // Clock and handshake
  input  wire logic   sys_clk,
  input  wire logic   req_ready_r,
  input  wire logic   res_valid_r,
  // Request
  output logic        req_valid,
  output vicm_op_t    req_op,
  output vicm_src_t   req_src,
  output logic [63:0] req_wide,
  output logic [31:0] req_vec,
  output logic [31:0] req_scalar,
  output logic [4:0]  req_imm,
  output logic [7:0]  req_idx,
  // Mask and policy
  output logic        mask_enable_field,
  output logic        mask_v0_bit,
  output logic        mask_undisturbed,
  output logic [31:0] req_old_elem,
  output logic        req_old_mask_bit
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    req_valid = 1'b0;
    req_op = OP_SEQ;
    req_src = SRC_VEC;
    {req_wide, req_vec, req_scalar, req_imm, req_idx, mask_enable_field, mask_v0_bit,
     mask_undisturbed, req_old_elem, req_old_mask_bit} = '0;
  end

  // Hold request until taken, then wait for its answer
  task automatic send(input vicm_op_t op, input vicm_src_t src, input logic [176:0] pay,
                      output int lat, output logic rdy);
    int n;
    @(posedge sys_clk);
    #1;
    req_valid = 1'b1;
    req_op = op;
    req_src = src;
    {req_wide, req_vec, req_scalar, req_imm, req_idx, mask_enable_field, mask_v0_bit,
     mask_undisturbed, req_old_elem, req_old_mask_bit} = pay;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (req_ready_r !== 1'b1 && n < 100);
    #1;
    rdy = req_ready_r;
    req_valid = 1'b0;
    // Released operands stop showing the old value
    {req_wide, req_vec, req_scalar} = ~{req_wide, req_vec, req_scalar};
    lat = 1;
    while (res_valid_r !== 1'b1 && lat < 100)
    begin
      @(posedge sys_clk);
      #1;
      lat++;
    end
  endtask
endmodule

//--- bench/vicm_unit_tb.sv
module vicm_unit_tb
  import vicm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    logic        ill;
    logic        msk;
    logic        mbit;
    logic        rdy;
    logic [31:0] lat;
    logic [31:0] d;
  } vicm_exp_t;

  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        req_valid, mask_enable_field, mask_v0_bit, mask_undisturbed, req_old_mask_bit;
  vicm_op_t    req_op;
  vicm_src_t   req_src;
  logic [63:0] req_wide;
  logic [31:0] req_vec, req_scalar, req_old_elem, res_data_r;
  logic [4:0]  req_imm;
  logic [7:0]  req_idx, res_idx_r;
  logic        req_ready_r, res_valid_r, res_mask_bit_r, res_is_mask_r;
  logic        res_tail_agnostic_r, res_write_r, res_illegal_r;
  int          n_fail = 0;
  int          tests_run = 0;
  logic [31:0] seed = 32'h0000_2406;

  always #20 sys_clk = ~sys_clk;

  vicm_issue_model u_issue (
    .sys_clk(sys_clk), .req_ready_r(req_ready_r), .res_valid_r(res_valid_r),
    .req_valid(req_valid), .req_op(req_op), .req_src(req_src), .req_wide(req_wide),
    .req_vec(req_vec), .req_scalar(req_scalar), .req_imm(req_imm), .req_idx(req_idx),
    .mask_enable_field(mask_enable_field), .mask_v0_bit(mask_v0_bit),
    .mask_undisturbed(mask_undisturbed), .req_old_elem(req_old_elem),
    .req_old_mask_bit(req_old_mask_bit)
  );

  vicm_unit DUT (
    .sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid), .req_op(req_op),
    .req_src(req_src), .req_wide(req_wide), .req_vec(req_vec), .req_scalar(req_scalar),
    .req_imm(req_imm), .req_idx(req_idx), .mask_enable_field(mask_enable_field),
    .mask_v0_bit(mask_v0_bit), .mask_undisturbed(mask_undisturbed),
    .req_old_elem(req_old_elem), .req_old_mask_bit(req_old_mask_bit),
    .req_ready_r(req_ready_r), .res_valid_r(res_valid_r), .res_data_r(res_data_r),
    .res_mask_bit_r(res_mask_bit_r), .res_is_mask_r(res_is_mask_r),
    .res_tail_agnostic_r(res_tail_agnostic_r), .res_write_r(res_write_r),
    .res_illegal_r(res_illegal_r), .res_idx_r(res_idx_r)
  );

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic vicm_exp_t predict(vicm_op_t op, vicm_src_t src, logic [63:0] w,
                                        logic [31:0] b, logic [2:0] pol, logic [31:0] old);
    vicm_exp_t   e;
    logic [31:0] a;
    logic [31:0] y;
    logic [63:0] p;
    logic        ovf;
    e = '0;
    p = '0;
    a = w[31:0];
    y = (src == SRC_IMM) ? {{27{b[4]}}, b[4:0]} : b;
    ovf = a == 32'h8000_0000 && y == 32'hFFFF_FFFF;
    e.msk = op <= OP_SGT;
    e.rdy = 1'b1;
    e.lat = 1;
    if (src == SRC_IMM)
      e.ill = op inside {OP_SLTU, OP_SLT} || (op >= OP_MINU && op <= OP_REM);
    else
      e.ill = src == SRC_VEC && op inside {OP_SGTU, OP_SGT};
    if (op >= OP_NSRL && src == SRC_IMM)
      y = 32'(b[4:0]);
    case (op)
      OP_SEQ: e.mbit = a == y;
      OP_SNE: e.mbit = a != y;
      OP_SLTU: e.mbit = a < y;
      OP_SLT: e.mbit = $signed(a) < $signed(y);
      OP_SLEU: e.mbit = a <= y;
      OP_SLE: e.mbit = $signed(a) <= $signed(y);
      OP_SGTU: e.mbit = a > y;
      OP_SGT: e.mbit = $signed(a) > $signed(y);
      OP_MINU: e.d = (a < y) ? a : y;
      OP_MIN: e.d = ($signed(a) < $signed(y)) ? a : y;
      OP_MAXU: e.d = (a > y) ? a : y;
      OP_MAX: e.d = ($signed(a) > $signed(y)) ? a : y;
      OP_MUL: p = a * y;
      OP_MULH: p = {{32{a[31]}}, a} * {{32{y[31]}}, y};
      OP_MULHU: p = {32'h0000_0000, a} * {32'h0000_0000, y};
      OP_MULHSU: p = {{32{a[31]}}, a} * {32'h0000_0000, y};
      OP_DIVU: e.d = (y == 0) ? '1 : a / y;
      OP_DIV: e.d = (y == 0) ? '1 : ovf ? a : $unsigned($signed(a) / $signed(y));
      OP_REMU: e.d = (y == 0) ? a : a % y;
      OP_REM: e.d = (y == 0) ? a : ovf ? '0 : $unsigned($signed(a) % $signed(y));
      OP_NSRL: p = w >> y[5:0];
      OP_NSRA: p = $signed(w) >>> y[5:0];
      default: e.ill = 1'b1;
    endcase
    if (op == OP_MUL || op >= OP_NSRL)
      e.d = p[31:0];
    else if (op inside {OP_MULH, OP_MULHU, OP_MULHSU})
      e.d = p[63:32];
    if (op >= OP_DIVU && op <= OP_REM && !e.ill)
    begin
      e.rdy = 1'b0;
      e.lat = (y == 0 || (ovf && op[0])) ? 2 : 34;
    end
    if (!pol[2] && !pol[1])
    begin
      e.d = pol[0] ? old : '1;
      e.mbit = !pol[0];
    end
    return e;
  endfunction

  task automatic chk1(string nm, logic e, logic g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chk32(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Pol is enable, mask bit, undisturbed; destination is mask register zero
  task automatic one(vicm_op_t op, vicm_src_t src, logic [63:0] w, logic [31:0] b,
                     logic [2:0] pol);
    vicm_exp_t   e;
    logic [31:0] old;
    int          lat;
    logic        rdy;
    old = rnd();
    e = predict(op, src, w, b, pol, old);
    u_issue.send(op, src, {w, b, b, b[4:0], old[15:8], pol, old, pol[1]}, lat, rdy);
    chk1("illegal", e.ill, res_illegal_r);
    chk1("write", !e.ill, res_write_r);
    chk32("index", 32'(old[15:8]), 32'(res_idx_r));
    chk32("unused field", 32'h0000_0000, e.msk ? res_data_r : 32'(res_mask_bit_r));
    if (e.ill)
      chk32("refused data", 32'h0000_0000, res_data_r);
    else
    begin
      chk1("is_mask", e.msk, res_is_mask_r);
      chk1("tail_agnostic", e.msk, res_tail_agnostic_r);
      chk1("ready", e.rdy, rdy);
      chk32("latency", e.lat, 32'(lat));
      if (e.msk)
        chk1("mask_bit", e.mbit, res_mask_bit_r);
      else
        chk32("data", e.d, res_data_r);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (20) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    chk1("ready after reset", 1'b1, req_ready_r);
    chk1("valid after reset", 1'b0, res_valid_r);
    $display("test reset done");
    for (int r = 0; r < 2; r++)
      for (int o = 0; o < 22; o++)
        for (int s = 0; s < 3; s++)
          one(vicm_op_t'(o), vicm_src_t'(s), {rnd(), rnd()}, rnd(), 3'b100);
    $display("test op table done");
    one(OP_SLEU, SRC_IMM, 64'h0000_0000_FFFF_FFF0, 32'h0000_0010, 3'b100);
    one(OP_SLEU, SRC_IMM, 64'h0000_0000_FFFF_FFFF, 32'h0000_001F, 3'b100);
    one(OP_SGT, SRC_IMM, 64'h0000_0000_0000_0000, 32'h0000_001F, 3'b100);
    one(OP_NSRL, SRC_SCA, 64'h1234_5678_9ABC_DEF0, 32'h0000_0000, 3'b100);
    one(OP_NSRL, SRC_SCA, 64'h1234_5678_9ABC_DEF0, 32'h0000_0044, 3'b100);
    one(OP_NSRA, SRC_VEC, 64'h8000_0000_0000_0000, 32'h0000_003F, 3'b100);
    one(OP_NSRA, SRC_IMM, 64'hF000_0000_1234_5678, 32'hFFFF_FFFF, 3'b100);
    one(OP_DIVU, SRC_SCA, 64'h0000_0000_1234_5678, 32'h0000_0000, 3'b100);
    one(OP_REMU, SRC_SCA, 64'h0000_0000_1234_5678, 32'h0000_0000, 3'b100);
    one(OP_DIV, SRC_VEC, 64'h0000_0000_8000_0000, 32'hFFFF_FFFF, 3'b100);
    one(OP_REM, SRC_VEC, 64'h0000_0000_8000_0000, 32'hFFFF_FFFF, 3'b100);
    one(OP_DIV, SRC_SCA, 64'h0000_0000_FFFF_FFF9, 32'h0000_0002, 3'b100);
    one(OP_MULH, SRC_VEC, 64'h0000_0000_8000_0000, 32'h8000_0000, 3'b100);
    one(OP_MULHSU, SRC_SCA, 64'h0000_0000_FFFF_FFFF, 32'hFFFF_FFFF, 3'b100);
    $display("test corners done");
    for (int k = 0; k < 8; k++)
    begin
      one(OP_SLT, SRC_VEC, {rnd(), rnd()}, rnd(), k[2:0]);
      one(OP_MUL, SRC_SCA, {rnd(), rnd()}, rnd(), k[2:0]);
    end
    $display("test masking done");
    summarize();
  end

  initial
  begin
    repeat (10000) @(posedge sys_clk);
    n_fail++;
    $display("[FAIL] watchdog expected done seen hang");
    summarize();
  end
endmodule
